//--- vkp_keyer.sv
// vkp_keyer: per-pixel keyer datapath with register port
`timescale 1ns/1ns

module vkp_keyer
    import vkp_pkg::*;
#(
    parameter int POS_N  = POS_TAPS,
    parameter int BORD_N = BORD_TAPS,
    parameter int LINE_N = LINE_LEN
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [REG_AW-1:0] regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [31:0]       regRdata,
    input  wire vkp_pix_s          pixIn,
    output logic      [DATA_W-1:0] pgmOut,
    output logic      [DATA_W-1:0] showKeyOut,
    output logic                   lineStartOut
);

    localparam int CENTER = POS_N / 2;
    localparam int DIV_N  = KW + RF + 1;
    localparam int COL_W  = $clog2(LINE_N);
    localparam int PW     = $clog2(POS_N);
    localparam int BW     = $clog2(BORD_N);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic        [CTRL_W-1:0] ctrl;
    logic signed [THR_W-1:0]  clip;
    logic        [GAIN_W-1:0] gain;
    logic signed [THR_W-1:0]  clipHi;
    logic signed [THR_W-1:0]  clipLo;
    logic        [7:0]        opacity;
    logic        [KW:0]       opacScale;
    logic        [PW-1:0]     keyPos;
    logic        [1:0]        keySize;
    logic        [BW-1:0]     bordSize;
    logic        [BW-1:0]     bordHoff;
    logic        [DATA_W-1:0] matte;
    logic        [DATA_W-1:0] coreLevel;
    logic                     keyActive;

    wire wrCtrl  = regWrite && (regAddr == REG_CTRL);
    wire wrClip  = regWrite && (regAddr == REG_CLIP) && !ctrl[CB_THR_MODE];
    wire wrGain  = regWrite && (regAddr == REG_GAIN) && !ctrl[CB_THR_MODE];
    wire wrHi    = regWrite && (regAddr == REG_CLIP_HI) && ctrl[CB_THR_MODE];
    wire wrLo    = regWrite && (regAddr == REG_CLIP_LO) && ctrl[CB_THR_MODE];
    wire wrOpac  = regWrite && (regAddr == REG_OPACITY);
    wire wrPos   = regWrite && (regAddr == REG_POS);
    wire wrSize  = regWrite && (regAddr == REG_SIZE);
    wire wrBord  = regWrite && (regAddr == REG_BORDER);
    wire wrMatte = regWrite && (regAddr == REG_MATTE);
    wire wrCore  = regWrite && (regAddr == REG_CORE);

    // clip/gain mode: thresholds follow clip and gain
    wire signed [THR_W-1:0]  wrVal    = regWdata[THR_W-1:0];
    wire signed [THR_W-1:0]  useClip  = wrClip ? wrVal : clip;
    wire        [GAIN_W-1:0] useGain  = wrGain ? regWdata[GAIN_W-1:0] : gain;
    wire signed [THR_W-1:0]  halfGain = THR_W'(useGain >> 1);
    wire signed [THR_W-1:0]  cgHi     = useClip + halfGain;
    wire signed [THR_W-1:0]  cgLo     = useClip - halfGain;
    // threshold mode: the untouched threshold is kept, clip and gain derived
    wire signed [THR_W-1:0]  newHi    = wrHi ? wrVal : clipHi;
    wire signed [THR_W-1:0]  newLo    = wrLo ? wrVal : clipLo;
    wire signed [THR_W:0]    span     = (THR_W+1)'(newHi) - (THR_W+1)'(newLo);
    wire signed [THR_W:0]    mid      = ((THR_W+1)'(newHi) + (THR_W+1)'(newLo)) >>> 1;
    // a threshold pair that would need negative or oversized gain is ignored
    wire                     spanOk   = (span >= 0) && (span <= (THR_W+1)'(9'h0FF));
    wire                     thrWr    = (wrHi || wrLo) && spanOk;
    wire                     gainMove = wrGain || thrWr;
    wire        [7:0]        opacClip = (regWdata[7:0] > PCT_FULL) ? PCT_FULL : regWdata[7:0];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl      <= RST_CTRL;
            clip      <= RST_CLIP;
            gain      <= RST_GAIN;
            clipHi    <= RST_HI;
            clipLo    <= RST_LO;
            opacity   <= RST_OPAC;
            opacScale <= KONE;
            keyPos    <= PW'(RST_POS);
            keySize   <= 2'h0;
            bordSize  <= '0;
            bordHoff  <= '0;
            matte     <= '0;
            coreLevel <= RST_CORE;
        end else begin
            if (wrCtrl) ctrl <= regWdata[CTRL_W-1:0];
            if (wrClip || wrGain) begin
                clip   <= useClip;
                gain   <= useGain;
                clipHi <= cgHi;
                clipLo <= cgLo;
            end
            if (thrWr) begin
                clipHi <= newHi;
                clipLo <= newLo;
                clip   <= THR_W'(mid);
                gain   <= GAIN_W'(span);
            end
            if (wrOpac) begin
                opacity   <= opacClip;
                opacScale <= (KW+1)'((19'(opacClip) * 19'(KONE)) / 19'(PCT_FULL));
            end
            if (wrPos)   keyPos    <= regWdata[PW-1:0];
            if (wrSize)  keySize   <= regWdata[1:0];
            if (wrBord)  bordSize  <= regWdata[BF_SIZE_LSB +: BW];
            if (wrBord)  bordHoff  <= regWdata[BF_HOFF_LSB +: BW];
            if (wrMatte) matte     <= regWdata[DATA_W-1:0];
            if (wrCore)  coreLevel <= regWdata[DATA_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // gain reciprocal: serial divide, old value held until done
    // ------------------------------------------------------------
    logic [RECIP_W-1:0] recip;
    logic [RECIP_W-1:0] quo;
    logic [DVS_W:0]     rem;
    logic [5:0]         divCnt;
    logic               divBusy;
    logic               divStart;

    wire [DVS_W-1:0] divisor  = DVS_W'(gain) * DVS_W'(YMAX);
    wire             numBit   = (divCnt == 6'(KW + RF));
    wire [DVS_W:0]   remShift = {rem[DVS_W-1:0], numBit};
    wire             remGe    = remShift >= {1'b0, divisor};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            divStart <= 1'b1;
            divBusy  <= 1'b0;
            divCnt   <= '0;
            rem      <= '0;
            quo      <= '0;
            recip    <= '0;
        end else begin
            divStart <= gainMove;
            if (divStart && gain != '0) begin
                divBusy <= 1'b1;
                divCnt  <= 6'(DIV_N - 1);
                rem     <= '0;
                quo     <= '0;
            end else if (divStart) begin
                // a hard key needs no slope, so nothing is left pending
                divBusy <= 1'b0;
            end else if (divBusy) begin
                rem    <= remGe ? remShift - {1'b0, divisor} : remShift;
                quo    <= {quo[RECIP_W-2:0], remGe};
                divCnt <= divCnt - 6'h1;
                if (divCnt == 6'h0) begin
                    divBusy <= 1'b0;
                    // rounded up so the upper threshold reaches full key, unless an odd gain was set in clip/gain mode
                    recip   <= {quo[RECIP_W-2:0], remGe} + RECIP_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // stage 1: cut positioning and narrowing
    // ------------------------------------------------------------
    vkp_pix_s          tapQ [POS_N];
    vkp_pix_s          side [1:6];
    logic [DATA_W-1:0] narrowCut;
    logic [DATA_W-1:0] cut1;

    always_comb begin
        narrowCut = tapQ[keyPos].cut;
        for (int j = 0; j < POS_N; j++) begin
            if ((j + int'(keySize) >= int'(keyPos)) && (j <= int'(keyPos) + int'(keySize))
                && (tapQ[j].cut < narrowCut)) begin
                narrowCut = tapQ[j].cut;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        tapQ[0] <= pixIn;
        for (int j = 1; j < POS_N; j++) begin
            tapQ[j] <= tapQ[j-1];
        end
        side[1] <= tapQ[CENTER];
        cut1    <= narrowCut;
        for (int s = 2; s <= 6; s++) begin
            side[s] <= side[s-1];
        end
    end

    // ------------------------------------------------------------
    // stage 2-4: clip, gain, clamp, S-shape, invert
    // ------------------------------------------------------------
    localparam logic signed [DIFF_W-1:0] PCT_S  = DIFF_W'(PCT_FULL);
    localparam logic signed [DIFF_W-1:0] YMAX_S = DIFF_W'(YMAX);

    logic signed [DIFF_W-1:0] diff2;
    logic        [KW:0]       k3;
    logic        [KW:0]       k4;

    wire signed [DIFF_W-1:0] cutPct = $signed(DIFF_W'(cut1)) * PCT_S;
    wire signed [DIFF_W-1:0] loAbs  = DIFF_W'(clipLo) * YMAX_S;
    wire signed [PROD_W-1:0] prod3  = PROD_W'(diff2) * $signed(PROD_W'(recip));
    wire signed [PROD_W-1:0] kRaw   = prod3 >>> RF;
    wire        [KW:0]       kHard  = (diff2 >= 0) ? KONE : '0;
    wire        [KW:0]       kSoft  = (kRaw <= 0) ? '0 :
                                      (kRaw >= PROD_W'(KONE)) ? KONE : kRaw[KW:0];
    wire        [2*KW+1:0]   kSq    = (2*KW+2)'(k3) * (2*KW+2)'(k3);
    wire        [KW+2:0]     sTerm  = (KW+3)'(3 * KONE) - (KW+3)'({k3, 1'b0});
    wire        [3*KW+4:0]   sFull  = (3*KW+5)'(kSq) * (3*KW+5)'(sTerm);
    // smoothstep keeps 0, half and full points, so thresholds and gain stay put
    wire        [KW:0]       kShape = ctrl[CB_SSHAPE] ? (KW+1)'(sFull >> (2*KW)) : k3;

    always_ff @(posedge ref_clk) begin
        diff2 <= cutPct - loAbs;
        k3    <= (gain == '0) ? kHard : kSoft;
        k4    <= ctrl[CB_INVERT] ? KONE - kShape : kShape;
    end

    // ------------------------------------------------------------
    // stage 5: border key, horizontal window plus one-line offset
    // ------------------------------------------------------------
    logic [KW:0]      hist    [BORD_N];
    logic [KW:0]      lineMem [LINE_N];
    logic [COL_W-1:0] col;
    logic [KW:0]      hKey;
    logic [KW:0]      k5;
    logic             inBorder5;

    always_comb begin
        hKey = '0;
        for (int j = 0; j < BORD_N; j++) begin
            if ((j >= int'(bordHoff)) && (j <= int'(bordHoff) + int'(bordSize))
                && (hist[j] > hKey)) begin
                hKey = hist[j];
            end
        end
    end

    wire [COL_W-1:0] colNow  = side[4].lineStart ? '0 : col;
    wire [KW:0]      vKey    = ctrl[CB_BORD_VOFF] ? lineMem[colNow] : hKey;
    wire [KW:0]      bordKey = ctrl[CB_BORDER] ? vKey : '0;

    always_ff @(posedge ref_clk) begin
        hist[0] <= k4;
        for (int j = 1; j < BORD_N; j++) begin
            hist[j] <= hist[j-1];
        end
        lineMem[colNow] <= hKey;
        k5              <= (bordKey > k4) ? bordKey : k4;
        inBorder5       <= bordKey > k4;
    end

    // column reset so the line memory never sees an unknown index
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            col <= '0;
        end else begin
            col <= colNow + COL_W'(1);
        end
    end

    // ------------------------------------------------------------
    // stage 6: masks and opacity
    // ------------------------------------------------------------
    logic [KW:0] kc6;
    logic        inBorder6;

    wire [DATA_W-1:0] maskSel  = ctrl[CB_MASK_WIPE] ? side[5].wipe : side[5].mask;
    wire              maskOn   = maskSel[DATA_W-1];
    wire [KW:0]       kMasked  = (ctrl[CB_INHIBIT] && maskOn) ? '0 :
                                 (ctrl[CB_FORCE] && maskOn) ? KONE : k5;
    wire [2*KW+1:0]   kOpac    = (2*KW+2)'(kMasked) * (2*KW+2)'(opacScale);

    always_ff @(posedge ref_clk) begin
        kc6       <= (KW+1)'(kOpac >> KW);
        inBorder6 <= inBorder5;
    end

    // ------------------------------------------------------------
    // stage 7: fill shaping, coring and composite
    // ------------------------------------------------------------
    wire [DATA_W-1:0]    srcFill  = ctrl[CB_SELF_KEY] ? side[6].cut : side[6].fill;
    wire [DATA_W-1:0]    bordFill = ctrl[CB_BORD_VID] ? srcFill : matte;
    wire [DATA_W-1:0]    fillSel  = inBorder6 ? bordFill : srcFill;
    wire                 doShape  = ctrl[CB_UNSHAPED] || ctrl[CB_SELF_KEY] || inBorder6;
    wire [DATA_W+KW:0]   fillMul  = (DATA_W+KW+1)'(fillSel) * (DATA_W+KW+1)'(kc6);
    wire [DATA_W-1:0]    shaped   = doShape ? DATA_W'(fillMul >> KW) : fillSel;
    wire                 coreHit  = ctrl[CB_CORING] && (kc6 != KONE) && (shaped <= coreLevel);
    wire [DATA_W-1:0]    cored    = coreHit ? '0 : shaped;
    wire [KW:0]          kComp    = KONE - kc6;
    wire [DATA_W+KW:0]   bgMul    = (DATA_W+KW+1)'(side[6].bg) * (DATA_W+KW+1)'(kComp);
    wire [DATA_W:0]      sum      = (DATA_W+1)'(cored) + (DATA_W+1)'(bgMul >> KW);
    wire [DATA_W+KW:0]   showMul  = (DATA_W+KW+1)'(kc6) * (DATA_W+KW+1)'(YMAX);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pgmOut       <= '0;
            showKeyOut   <= '0;
            lineStartOut <= 1'b0;
            keyActive    <= 1'b0;
        end else begin
            // a fill hotter than the hole would overflow; saturate at white
            pgmOut       <= sum[DATA_W] ? YMAX : sum[DATA_W-1:0];
            showKeyOut   <= DATA_W'(showMul >> KW);
            lineStartOut <= side[6].lineStart;
            keyActive    <= kc6 != '0;
        end
    end

    // ------------------------------------------------------------
    // register read port, data valid the cycle after the strobe only
    // ------------------------------------------------------------
    logic [31:0] rdMux;

    always_comb begin
        unique case (regAddr)
            REG_CTRL:    rdMux = 32'(ctrl);
            REG_CLIP:    rdMux = 32'(unsigned'(clip));
            REG_GAIN:    rdMux = 32'(gain);
            REG_CLIP_HI: rdMux = 32'(unsigned'(clipHi));
            REG_CLIP_LO: rdMux = 32'(unsigned'(clipLo));
            REG_OPACITY: rdMux = 32'(opacity);
            REG_POS:     rdMux = 32'(keyPos);
            REG_SIZE:    rdMux = 32'(keySize);
            REG_BORDER:  rdMux = 32'({bordHoff, bordSize});
            REG_MATTE:   rdMux = 32'(matte);
            REG_CORE:    rdMux = 32'(coreLevel);
            REG_STATUS:  rdMux = 32'({keyActive, divBusy});
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdata <= 32'h0000_0000;
        end else begin
            // idle zero keeps a stale word from being taken for an answer
            regRdata <= regRead ? rdMux : 32'h0000_0000;
        end
    end

endmodule : vkp_keyer

//--- vkp_pkg.sv
// vkp_pkg: shared constants, register map and pixel carrier of the video key processor
package vkp_pkg;

    // ------------------------------------------------------------
    // pixel and key widths
    // ------------------------------------------------------------
    localparam int DATA_W   = 10;                  // video sample width
    localparam int KW       = 10;                  // key fraction bits
    localparam int RF       = 16;                  // reciprocal fraction bits
    localparam int DIFF_W   = 22;                  // signed cut-minus-threshold width
    localparam int RECIP_W  = KW + RF + 1;         // reciprocal width
    localparam int PROD_W   = DIFF_W + RECIP_W + 1;
    localparam int THR_W    = 10;                  // signed percent thresholds
    localparam int GAIN_W   = 8;                   // unsigned gain percent
    localparam int DVS_W    = GAIN_W + DATA_W;     // divisor width
    localparam logic [DATA_W-1:0] YMAX = 10'h3FF;  // white level
    localparam logic [KW:0]       KONE = 11'h400;  // fully opaque key
    localparam logic [7:0]        PCT_FULL = 8'h64; // 100 percent

    // ------------------------------------------------------------
    // pipeline geometry defaults
    // ------------------------------------------------------------
    localparam int POS_TAPS  = 8;                  // cut positioning window
    localparam int BORD_TAPS = 16;                 // border history window
    localparam int LINE_LEN  = 2048;               // line memory depth

    // ------------------------------------------------------------
    // register map (word index on the register port)
    // ------------------------------------------------------------
    localparam int REG_AW = 4;
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_CLIP    = 4'h1;
    localparam logic [3:0] REG_GAIN    = 4'h2;
    localparam logic [3:0] REG_CLIP_HI = 4'h3;
    localparam logic [3:0] REG_CLIP_LO = 4'h4;
    localparam logic [3:0] REG_OPACITY = 4'h5;
    localparam logic [3:0] REG_POS     = 4'h6;
    localparam logic [3:0] REG_SIZE    = 4'h7;
    localparam logic [3:0] REG_BORDER  = 4'h8;
    localparam logic [3:0] REG_MATTE   = 4'h9;
    localparam logic [3:0] REG_CORE    = 4'hA;
    localparam logic [3:0] REG_STATUS  = 4'hB;

    // control bit positions
    localparam int CB_THR_MODE  = 0;
    localparam int CB_SSHAPE    = 1;
    localparam int CB_INVERT    = 2;
    localparam int CB_SELF_KEY  = 3;
    localparam int CB_UNSHAPED  = 4;
    localparam int CB_CORING    = 5;
    localparam int CB_INHIBIT   = 6;
    localparam int CB_FORCE     = 7;
    localparam int CB_MASK_WIPE = 8;
    localparam int CB_BORDER    = 9;
    localparam int CB_BORD_VID  = 10;
    localparam int CB_BORD_VOFF = 11;
    localparam int CTRL_W       = 12;

    // border register fields
    localparam int BF_SIZE_LSB = 0;
    localparam int BF_HOFF_LSB = 4;

    // reset values: fixed linear key, clip 50 percent at unity gain
    localparam logic [CTRL_W-1:0] RST_CTRL = 12'h000;
    localparam logic [THR_W-1:0]  RST_CLIP = 10'h032;
    localparam logic [GAIN_W-1:0] RST_GAIN = 8'h64;
    localparam logic [THR_W-1:0]  RST_HI   = 10'h064;
    localparam logic [THR_W-1:0]  RST_LO   = 10'h000;
    localparam logic [7:0]        RST_OPAC = 8'h64;
    localparam logic [2:0]        RST_POS  = 3'h4;
    localparam logic [DATA_W-1:0] RST_CORE = 10'h010;

    // ------------------------------------------------------------
    // pixel carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic              lineStart;
        logic [DATA_W-1:0] bg;
        logic [DATA_W-1:0] cut;
        logic [DATA_W-1:0] fill;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] wipe;
    } vkp_pix_s;

endpackage : vkp_pkg

//--- vkp_video_src.sv
// vkp_video_src: pixel source model feeding background, cut and fill
`timescale 1ns/1ns
module vkp_video_src
    import vkp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic run,
    output vkp_pix_s  pix
);
    logic [5:0] col = 6'h00;
    // held at zero when stopped so reset flushes a clean pipeline
    always_ff @(posedge ref_clk) begin
        col <= run ? col + 6'h01 : 6'h00;
        pix <= run ? {col == 6'h3F, 10'($urandom), 10'($urandom), 10'($urandom),
                      10'($urandom), 10'($urandom)} : '0;
    end
endmodule : vkp_video_src

//--- vkp_keyer_monitor.sv
// vkp_keyer_monitor: port-level checks for the keyer
`timescale 1ns/1ns
module vkp_keyer_monitor
    import vkp_pkg::*;
#(
    parameter int POS_N  = POS_TAPS,
    parameter int BORD_N = BORD_TAPS,
    parameter int LINE_N = LINE_LEN
) (
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [31:0]       regWdata,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [31:0]       regRdata,
    input wire vkp_pix_s          pixIn,
    input wire logic [DATA_W-1:0] pgmOut,
    input wire logic [DATA_W-1:0] showKeyOut,
    input wire logic              lineStartOut
);
    localparam int LAT = POS_N / 2 + 8;
    logic thrMode;
    // mirrors the mode bit so gain writes are only judged when accepted
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            thrMode <= 1'b0;
        end else if (regWrite && regAddr == REG_CTRL) begin
            thrMode <= regWdata[CB_THR_MODE];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_gain_hi;
        (!thrMode && regWrite && regAddr == REG_CLIP) ##1 !regWrite
        ##1 (regWrite && regAddr == REG_GAIN) ##1 !regWrite ##1 (regRead && regAddr == REG_CLIP_HI);
    endsequence
    sequence s_ctrl_wr_rd;
        (regWrite && regAddr == REG_CTRL) ##1 !regWrite ##1 (regRead && regAddr == REG_CTRL);
    endsequence
    rdata_idle_a: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data not zero outside read slot");
    unmapped_read_a: assert property (regRead && regAddr > REG_STATUS |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (s_ctrl_wr_rd |=> regRdata[11:0] == $past(regWdata[11:0], 3))
        else $error("control read back wrong");
    hi_recalc_a: assert property (s_gain_hi |=>
        regRdata[9:0] == 10'($past(regWdata[9:0], 5) + ($past(regWdata[7:0], 3) >> 1)))
        else $error("upper threshold not clip plus half gain");
    div_busy_a: assert property (s_gain_hi ##1 !regRead ##1 (regRead && regAddr == REG_STATUS)
        |=> regRdata[0] == ($past(regWdata[7:0], 5) != 8'h00))
        else $error("divider not busy after gain change");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
        pgmOut == 10'h000 && showKeyOut == 10'h000 && !lineStartOut)
        else $error("outputs not quiet in reset");
    line_align_a: assert property (pixIn.lineStart |-> ##LAT lineStartOut)
        else $error("line start misaligned");
    opaque_fill_a: assert property (showKeyOut == 10'h3FF |-> pgmOut == $past(pixIn.fill, LAT))
        else $error("opaque pixel not pure fill");
endmodule : vkp_keyer_monitor

bind vkp_keyer vkp_keyer_monitor #(.POS_N(POS_N), .BORD_N(BORD_N), .LINE_N(LINE_N)) u_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pixIn(pixIn),
    .pgmOut(pgmOut), .showKeyOut(showKeyOut), .lineStartOut(lineStartOut));

//--- testbench.sv
// testbench: keyer against an integer key model
`timescale 1ns/1ns
module testbench;
    import vkp_pkg::*;
    localparam int LAT = POS_TAPS / 2 + 8;
    logic              ref_clk, sys_rst, regWrite, regRead, run, lineStartOut;
    logic [REG_AW-1:0] regAddr;
    logic [31:0]       regWdata, regRdata, rv;
    logic [DATA_W-1:0] pgmOut, showKeyOut;
    vkp_pix_s          pixIn;
    int                error_cnt = 0, cmp_count = 0, clip, gain, lo, inv, opac = 100, shp = 0;
    int                q[$];
    vkp_keyer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pixIn(pixIn),
        .pgmOut(pgmOut), .showKeyOut(showKeyOut), .lineStartOut(lineStartOut));
    vkp_video_src src (.ref_clk(ref_clk), .run(run), .pix(pixIn));
    always #25 ref_clk = ~ref_clk;
    task chk(string n, logic [31:0] got, int e);
        cmp_count++;
        if (got !== 32'(e)) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, got);
        end
    endtask : chk
    task wrap_up;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task wr(logic [3:0] a, int d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= 32'(d);
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    task rd(logic [3:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rv = regRdata;
    endtask : rd
    task rdc(string n, logic [3:0] a, int e);
        rd(a);
        chk(n, rv, e);
    endtask : rdc
    // the key slope only settles once the reciprocal is done
    task settle;
        int i;
        for (i = 0; i < 100; i++) begin
            rd(REG_STATUS);
            if (rv[0] === 1'b0) break;
        end
        if (i == 100) begin
            chk("divider", 1, 0);
            wrap_up();
        end
    endtask : settle
    function automatic int model(vkp_pix_s p);
        longint v;
        int     k, o, f;
        if (gain == 0) k = (int'(p.cut) * 100 >= clip * 1023) ? 1024 : 0;
        else begin
            v = longint'(int'(p.cut) * 100 - lo * 1023) * ((2 ** 26) / (gain * 1023) + 1) >>> 16;
            k = (v < 0) ? 0 : ((v > 1024) ? 1024 : int'(v));
        end
        if (inv != 0) k = 1024 - k;
        k = (k * ((opac * 1024) / 100)) >> 10;
        f = (shp != 0) ? (int'(p.fill) * k) >> 10 : int'(p.fill);
        o = f + ((int'(p.bg) * (1024 - k)) >> 10);
        if (o > 1023) o = 1023;
        return o | (((k * 1023) >> 10) << 10) | (int'(p.lineStart) << 20);
    endfunction : model
    task run_px(int n);
        int e;
        q.delete();
        repeat (n + LAT) begin
            @(posedge ref_clk);
            #1 q.push_back(model(pixIn));
            if (q.size() > LAT) begin
                e = q.pop_front();
                chk("pgm", pgmOut, e & 1023);
                chk("show", showKeyOut, (e >> 10) & 1023);
                chk("line", lineStartOut, e >> 20);
            end
        end
    endtask : run_px
    initial begin
        static int tc[3] = '{50, 60, 40};
        static int tg[3] = '{50, 0, 200};
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {regWrite, regRead, run, regAddr, regWdata, rv} = '0;
        void'($urandom(48321));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        settle();
        rdc("clip", REG_CLIP, 50);
        rdc("hi", REG_CLIP_HI, 100);
        rdc("lo", REG_CLIP_LO, 0);
        {clip, gain, lo, inv} = {32'd50, 32'd100, 32'd0, 32'd0};
        run_px(200);
        for (int i = 0; i < 3; i++) begin
            wr(REG_CLIP, tc[i]);
            wr(REG_GAIN, tg[i]);
            rdc("hi", REG_CLIP_HI, tc[i] + tg[i] / 2);
            clip = tc[i];
            gain = tg[i];
            lo = clip - gain / 2;
            settle();
            run_px(200);
        end
        wr(REG_CLIP, 50);
        wr(REG_GAIN, 100);
        wr(REG_CTRL, 4);
        rdc("ctrl", REG_CTRL, 4);
        {clip, gain, lo, inv} = {32'd50, 32'd100, 32'd0, 32'd1};
        settle();
        run_px(150);
        wr(REG_CTRL, 1);
        wr(REG_CLIP_HI, 80);
        wr(REG_CLIP_LO, 20);
        wr(REG_GAIN, 7);
        wr(4'hD, 5);
        rdc("spare", 4'hD, 0);
        rdc("clip", REG_CLIP, 50);
        rdc("gain", REG_GAIN, 60);
        {gain, lo, inv} = {32'd60, 32'd20, 32'd0};
        settle();
        run_px(200);
        opac = $urandom % 101;
        wr(REG_CTRL, 16);
        wr(REG_OPACITY, opac);
        wr(REG_BORDER, 32'h5A);
        rdc("opac", REG_OPACITY, opac);
        rdc("border", REG_BORDER, 32'h5A);
        shp = 1;
        run_px(200);
        wrap_up();
    end
endmodule : testbench
